// ==== logic/cio_handler.sv ====
// The placing of the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module cio_handler
   import cio_pkg::*;
#(
   parameter int TIMEOUT = RESP_TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic select_channel,
   input wire logic start_io,
   input wire logic test_io,
   input wire logic halt_io,
   input wire logic test_channel,
   input wire logic [7:0] unit_address_bus_out,
   input wire logic target_is_multiplex,
   input wire logic sub_working,
   input wire logic sub_burst,
   input wire logic end_intr_pending,
   input wire logic all_burst,
   input wire logic chan_operational,
   input wire logic unit_available,
   output logic [1:0] cond_code,
   output logic release_cpu,
   output logic [7:0] bus_out,
   output logic address_out,
   output logic select_out,
   output logic command_out,
   input wire logic operational_in,
   input wire logic status_in,
   input wire logic select_in,
   input wire logic [7:0] bus_in,
   output logic service_out,
   output logic interrupt_request,
   output logic status_accepted_wait,
   output logic mem_req,
   output logic mem_write,
   output logic [23:0] mem_addr,
   output logic [63:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output logic [3:0] prot_key_reg,
   output logic [23:0] ccw_addr_reg,
   output logic [7:0] ccw_cmd_reg,
   output logic [23:0] ccw_data_reg,
   output logic ccw_valid,
   output logic op_started
);

//==============================================================================
// Decoding.
function automatic cio_op_e decode_cmd(input logic [7:0] c);
   if (c[1:0] == 2'h1) return OP_WRITE;
   if (c[1:0] == 2'h2) return OP_READ;
   if (c[1:0] == 2'h3) return OP_CONTROL;
   if (c[3:0] == 4'h4) return OP_SENSE;
   if (c[3:0] == 4'h8) return OP_BRANCH;
   if (c[3:0] == 4'hc) return OP_READ_BACK;
   return OP_INVALID;
endfunction

typedef enum logic [3:0] {
   S_IDLE, S_ADDR, S_SEL, S_WAIT, S_CMD, S_STAT, S_STORE, S_FETCH_AW,
   S_FETCH_CW, S_DONE
} cio_state_e;

cio_state_e state_reg;
logic [7:0] unit_reg;
logic [7:0] pend_unit_reg;
logic pend_valid_reg;
logic [7:0] dev_stat_reg;
logic [7:0] chan_stat_reg;
logic [1:0] code_reg;
logic is_halt_reg;
logic is_start_reg;
logic [7:0] cnt_reg;
logic [31:0] aw_reg;
logic burst_halt_reg;

assign cond_code = code_reg;
assign release_cpu = (state_reg == S_DONE); // [RL25]
assign interrupt_request = pend_valid_reg;
assign mem_wdata = {24'h0, unit_reg, dev_stat_reg, chan_stat_reg, 16'h0};
assign bus_out = (state_reg == S_CMD) ? (is_start_reg ? ccw_cmd_reg :
   CMD_TEST_IO) : unit_reg;

//==============================================================================
// Sequencer.
always_ff @(posedge clk) begin
   if (!nrst) begin
      state_reg <= S_IDLE;
      unit_reg <= 8'h0;
      pend_unit_reg <= 8'h0;
      pend_valid_reg <= 1'b0;
      dev_stat_reg <= 8'h0;
      chan_stat_reg <= 8'h0;
      code_reg <= CC_AVAIL;
      is_halt_reg <= 1'b0;
      is_start_reg <= 1'b0;
      cnt_reg <= 8'h0;
      aw_reg <= 32'h0;
      burst_halt_reg <= 1'b0;
      address_out <= 1'b0;
      select_out <= 1'b0;
      command_out <= 1'b0;
      service_out <= 1'b0;
      status_accepted_wait <= 1'b0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 24'h0;
      prot_key_reg <= 4'h0;
      ccw_addr_reg <= 24'h0;
      ccw_cmd_reg <= 8'h0;
      ccw_data_reg <= 24'h0;
      ccw_valid <= 1'b0;
      op_started <= 1'b0;
   end else begin
      op_started <= 1'b0;
      case (state_reg)
         S_IDLE: begin
            is_halt_reg <= 1'b0;
            is_start_reg <= 1'b0;
            if (select_channel && test_channel) begin
               // Unit address is ignored here. [RL14] [RL15]
               if (!chan_operational)
                  code_reg <= CC_NOTOP;
               else if (pend_valid_reg)
                  code_reg <= CC_STORED;
               else if (all_burst)
                  code_reg <= CC_BUSY;
               else
                  code_reg <= CC_AVAIL;
               state_reg <= S_DONE;
            end else if (select_channel && test_io) begin
               if (pend_valid_reg &&
                     unit_address_bus_out == pend_unit_reg) begin
                  unit_reg <= pend_unit_reg;
                  mem_addr <= ADDR_STATUS_WORD; // [RL2]
                  mem_write <= 1'b1;
                  mem_req <= 1'b1;
                  code_reg <= CC_STORED;
                  state_reg <= S_STORE;
               end else if (!unit_available) begin
                  code_reg <= CC_NOTOP; // [RL23]
                  state_reg <= S_DONE;
               end else if (sub_working || sub_burst) begin
                  code_reg <= CC_BUSY; // [RL6]
                  state_reg <= S_DONE;
               end else begin
                  unit_reg <= unit_address_bus_out; // [RL3]
                  chan_stat_reg <= 8'h0;
                  state_reg <= S_ADDR;
               end
            end else if (select_channel && halt_io) begin
               unit_reg <= unit_address_bus_out;
               is_halt_reg <= 1'b1;
               if (!unit_available) begin
                  code_reg <= CC_NOTOP; // [RL23]
                  state_reg <= S_DONE;
               end else if ((target_is_multiplex && !sub_burst) ||
                     (!target_is_multiplex && end_intr_pending)) begin
                  code_reg <= CC_AVAIL; // [RL8]
                  state_reg <= S_DONE;
               end else if (sub_working || sub_burst) begin
                  address_out <= 1'b1; // [RL9]
                  select_out <= 1'b0;
                  code_reg <= CC_BUSY;
                  if (target_is_multiplex) begin
                     burst_halt_reg <= 1'b1; // [RL10]
                     status_accepted_wait <= 1'b1;
                  end else begin
                     pend_valid_reg <= 1'b1;
                     pend_unit_reg <= unit_address_bus_out;
                  end
                  state_reg <= S_DONE;
               end else begin
                  state_reg <= S_ADDR; // [RL11]
               end
            end else if (select_channel && start_io) begin
               unit_reg <= unit_address_bus_out;
               is_start_reg <= 1'b1;
               // Status left by an earlier instruction must not fail a start.
               dev_stat_reg <= 8'h0;
               chan_stat_reg <= 8'h0;
               if (!unit_available) begin
                  code_reg <= CC_NOTOP;
                  state_reg <= S_DONE;
               end else if (sub_working || sub_burst) begin
                  code_reg <= CC_BUSY;
                  state_reg <= S_DONE;
               end else begin
                  mem_addr <= ADDR_ADDRESS_WORD; // [RL17]
                  mem_write <= 1'b0;
                  mem_req <= 1'b1;
                  state_reg <= S_FETCH_AW;
               end
            end
            if (burst_halt_reg && status_in) begin
               service_out <= 1'b1;
               burst_halt_reg <= 1'b0;
               status_accepted_wait <= 1'b0;
               pend_valid_reg <= 1'b1; // [RL10]
               pend_unit_reg <= unit_reg;
            end else begin
               service_out <= 1'b0;
            end
            if (address_out && !operational_in && !status_in)
               address_out <= 1'b0;
         end
         S_FETCH_AW: if (mem_ack) begin
            mem_req <= 1'b0;
            aw_reg <= mem_rdata;
            prot_key_reg <= mem_rdata[31:28]; // [RL18]
            if (mem_rdata[27:24] != 4'h0 || mem_rdata[2:0] != 3'h0 ||
                  mem_rdata[23:0] == 24'h0) begin
               chan_stat_reg <= CHST_PROG_CHECK; // [RL19] [RL20]
               dev_stat_reg <= 8'h0;
               mem_addr <= ADDR_STATUS_WORD;
               mem_write <= 1'b1;
               mem_req <= 1'b1;
               code_reg <= CC_STORED;
               state_reg <= S_STORE;
            end else begin
               ccw_addr_reg <= mem_rdata[23:0];
               mem_addr <= mem_rdata[23:0]; // [RL21]
               mem_req <= 1'b1;
               state_reg <= S_FETCH_CW;
            end
         end
         S_FETCH_CW: if (mem_ack) begin
            mem_req <= 1'b0;
            ccw_cmd_reg <= mem_rdata[31:24]; // [RL22]
            ccw_data_reg <= mem_rdata[23:0];
            ccw_valid <= 1'b1; // [RL21]
            ccw_addr_reg <= ccw_addr_reg + 24'h8;
            if (decode_cmd(mem_rdata[31:24]) == OP_INVALID ||
                  decode_cmd(mem_rdata[31:24]) == OP_BRANCH) begin
               chan_stat_reg <= CHST_PROG_CHECK;
               mem_addr <= ADDR_STATUS_WORD;
               mem_write <= 1'b1;
               mem_req <= 1'b1;
               code_reg <= CC_STORED;
               state_reg <= S_STORE;
            end else begin
               state_reg <= S_ADDR; // [RL16]
            end
         end
         S_ADDR: begin
            address_out <= 1'b1; // [RL24]
            cnt_reg <= 8'h0;
            state_reg <= S_SEL;
         end
         S_SEL: begin
            cnt_reg <= cnt_reg + 8'h1;
            if (cnt_reg == 8'(SEL_DELAY_CYC - 1)) begin
               select_out <= 1'b1; // [RL24]
               cnt_reg <= 8'h0;
               state_reg <= S_WAIT;
            end
         end
         S_WAIT: begin
            cnt_reg <= cnt_reg + 8'h1;
            if (select_in) begin
               select_out <= 1'b0;
               address_out <= 1'b0;
               code_reg <= CC_NOTOP; // [RL13]
               state_reg <= S_DONE;
            end else if (status_in && !operational_in) begin
               // Short busy answer from the control unit. [RL12]
               dev_stat_reg <= bus_in;
               chan_stat_reg <= 8'h0;
               service_out <= 1'b1;
               select_out <= 1'b0;
               address_out <= 1'b0;
               mem_addr <= ADDR_STATUS_WORD;
               mem_write <= 1'b1;
               mem_req <= 1'b1;
               code_reg <= CC_STORED;
               state_reg <= S_STORE;
            end else if (operational_in) begin
               if (is_halt_reg) begin
                  // Interface disconnect: address out with select out down.
                  select_out <= 1'b0; // [RL11]
                  dev_stat_reg <= 8'h0;
                  chan_stat_reg <= 8'h0;
                  mem_addr <= ADDR_STATUS_WORD;
                  mem_write <= 1'b1;
                  mem_req <= 1'b1;
                  code_reg <= CC_STORED;
                  state_reg <= S_STORE;
               end else begin
                  address_out <= 1'b0;
                  command_out <= 1'b1;
                  state_reg <= S_CMD;
               end
            end else if (cnt_reg == 8'(TIMEOUT)) begin
               select_out <= 1'b0;
               address_out <= 1'b0;
               code_reg <= CC_NOTOP;
               state_reg <= S_DONE;
            end
         end
         S_CMD: if (status_in) begin
            command_out <= 1'b0;
            state_reg <= S_STAT;
         end
         S_STAT: begin
            select_out <= 1'b0;
            service_out <= 1'b1;
            dev_stat_reg <= bus_in; // [RL7]
            if (bus_in == 8'h0 && chan_stat_reg == 8'h0) begin
               code_reg <= CC_AVAIL; // [RL4]
               op_started <= is_start_reg;
               state_reg <= S_DONE;
            end else begin
               mem_addr <= ADDR_STATUS_WORD; // [RL4]
               mem_write <= 1'b1;
               mem_req <= 1'b1;
               code_reg <= CC_STORED;
               state_reg <= S_STORE;
            end
         end
         S_STORE: begin
            service_out <= 1'b0;
            address_out <= 1'b0;
            if (mem_ack) begin
               mem_req <= 1'b0;
               mem_write <= 1'b0;
               if (!is_halt_reg && !is_start_reg)
                  pend_valid_reg <= 1'b0; // [RL5]
               state_reg <= S_DONE;
            end
         end
         S_DONE: begin
            service_out <= 1'b0;
            state_reg <= S_IDLE;
         end
         default: state_reg <= S_IDLE;
      endcase
   end
end

endmodule
`default_nettype wire

// ==== logic/cio_pkg.sv ====
//==============================================================================
// Behaviour
// RL1 - Processor starts test I/O with address, select
// RL2 - Pending address match stores status at 64
// RL3 - Mismatch, idle: select device, send test code
// RL4 - Nonzero status stores word, code 01; else 00
// RL5 - Code 01 clears interruption in channel, device
// RL6 - Busy or burst subchannel: code 10, no action
// RL7 - Busy alone device; with modifier control unit
// RL8 - Halt multiplex or end-pending selector: code 00
// RL9 - Halt working selector: address out, code 10
// RL10 - Burst multiplex halt waits for status accepted
// RL11 - Halt available: operational in, disconnect, 01
// RL12 - Control unit busy: device status, zero channel
// RL13 - Select in returned during halt: code 11
// RL14 - Test channel carries no unit address
// RL15 - Test channel codes 00/01/10/11 from state
// RL16 - Six commands; all but branch start operation
// RL17 - Address word fetched from 72 only at start
// RL18 - Key 0-3, zero 4-7, command address 8-31
// RL19 - Command address doubleword aligned
// RL20 - Bad address word: program check, no start
// RL21 - Command word fetched once, kept in subchannel
// RL22 - Command code 0-7, data address 8-31
// RL23 - Code 11 means unit unavailable
// RL24 - Address out, select out 250 ns later
// RL25 - Code held stable with single release pulse
package cio_pkg;
   localparam logic [1:0] CC_AVAIL = 2'h0;
   localparam logic [1:0] CC_STORED = 2'h1;
   localparam logic [1:0] CC_BUSY = 2'h2;
   localparam logic [1:0] CC_NOTOP = 2'h3;
   localparam logic [23:0] ADDR_STATUS_WORD = 24'h000040;
   localparam logic [23:0] ADDR_ADDRESS_WORD = 24'h000048;
   localparam logic [7:0] CMD_TEST_IO = 8'h00;
   localparam logic [7:0] CMD_SENSE = 8'h04;
   localparam logic [7:0] CMD_BRANCH = 8'h08;
   localparam logic [7:0] STAT_MODIFIER = 8'h40;
   localparam logic [7:0] STAT_BUSY = 8'h10;
   localparam logic [7:0] CHST_PROG_CHECK = 8'h20;
   localparam int SEL_DELAY_NS = 250;
   localparam int CLK_NS = 40;
   localparam int SEL_DELAY_CYC = (SEL_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESP_TIMEOUT_CYC = 255;
   typedef enum logic [2:0] {
      OP_WRITE, OP_READ, OP_READ_BACK, OP_CONTROL, OP_SENSE, OP_BRANCH,
      OP_INVALID
   } cio_op_e;
endpackage

// ==== tb/cio_handler_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module cio_handler_props
   import cio_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic select_channel,
   input wire logic start_io,
   input wire logic halt_io,
   input wire logic test_channel,
   input wire logic sub_working,
   input wire logic sub_burst,
   input wire logic all_burst,
   input wire logic chan_operational,
   input wire logic interrupt_request,
   input wire logic operational_in,
   input wire logic [1:0] cond_code,
   input wire logic release_cpu,
   input wire logic address_out,
   input wire logic select_out,
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic [23:0] mem_addr,
   input wire logic op_started,
   input wire logic [7:0] ccw_cmd_reg
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   //=====================================================================
   // Release, condition codes and selection timing
   sequence s_sel_wait; !select_out [*7]; endsequence
   sequence s_sel_up; s_sel_wait ##1 select_out; endsequence
   property p_rel_one; release_cpu |=> !release_cpu; endproperty
   a_rel_one: assert property (p_rel_one) else $error("long release");
   property p_code_hold; release_cpu |=> $stable(cond_code); endproperty
   a_code_hold: assert property (p_code_hold) else $error("code moved");
   property p_tch_rel;
      $rose(test_channel) && select_channel |-> ##[1:2] release_cpu;
   endproperty
   a_tch_rel: assert property (p_tch_rel) else $error("tch late");
   property p_tch_down;
      release_cpu && test_channel && !chan_operational |-> cond_code == CC_NOTOP;
   endproperty
   a_tch_down: assert property (p_tch_down) else $error("tch down");
   property p_tch_burst;
      release_cpu && test_channel && chan_operational && all_burst &&
         !interrupt_request |-> cond_code == CC_BUSY;
   endproperty
   a_tch_burst: assert property (p_tch_burst) else $error("tch burst");
   // A disconnect also raises address out, so only a fresh selection counts.
   property p_sel_gap;
      $rose(address_out) && !select_out && !operational_in &&
         !(halt_io && (sub_working || sub_burst)) |-> s_sel_up;
   endproperty
   a_sel_gap: assert property (p_sel_gap) else $error("select gap");
   property p_csw_loc; mem_req && mem_write |-> mem_addr == ADDR_STATUS_WORD;
   endproperty
   a_csw_loc: assert property (p_csw_loc) else $error("store loc");
   property p_caw_start;
      mem_req && !mem_write && mem_addr == ADDR_ADDRESS_WORD |-> start_io;
   endproperty
   a_caw_start: assert property (p_caw_start) else $error("caw read");
   property p_op_cmd; op_started |-> start_io && ccw_cmd_reg != CMD_BRANCH;
   endproperty
   a_op_cmd: assert property (p_op_cmd) else $error("bad start");
endmodule
`default_nettype wire

// ==== tb/cio_handler_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cio_handler_tb_top
   import cio_pkg::*;
;
   logic clk, nrst, select_channel, start_io, test_io, halt_io;
   logic test_channel, target_is_multiplex, sub_working, sub_burst;
   logic end_intr_pending, all_burst, chan_operational, unit_available;
   logic release_cpu, address_out, select_out, command_out, service_out;
   logic operational_in, status_in, select_in, interrupt_request;
   logic status_accepted_wait, mem_req, mem_write, mem_ack, ccw_valid;
   logic op_started;
   logic [1:0] cond_code, cc, mode;
   logic [3:0] prot_key_reg;
   logic [6:0] sv;
   logic [7:0] unit_address_bus_out, bus_out, bus_in, ccw_cmd_reg, lc, ds;
   logic [23:0] mem_addr, ccw_addr_reg, ccw_data_reg;
   logic [31:0] mem_rdata, channel_address_word, channel_command_word;
   logic [63:0] mem_wdata, wd;
   logic [12:0] tab [8] = '{{7'h00, 4'h1, 2'h3}, {7'h06, 4'h1, 2'h2},
      {7'h03, 4'h1, 2'h0}, {7'h23, 4'h4, 2'h2}, {7'h43, 4'h2, 2'h0},
      {7'h0b, 4'h2, 2'h0}, {7'h23, 4'h2, 2'h2}, {7'h53, 4'h2, 2'h2}};
   logic [63:0] bad [4] = '{64'h51000100_01002000, 64'h50000104_01002000,
      64'h50000000_01002000, 64'h50000100_08002000};
   int mismatches, num_checks, nw, ops;
   assign {target_is_multiplex, sub_working, sub_burst, end_intr_pending,
      all_burst, chan_operational, unit_available} = sv;
   always #20 clk = ~clk;
   cio_handler u_cio_handler (.clk, .nrst, .select_channel, .start_io,
      .test_io, .halt_io, .test_channel, .unit_address_bus_out,
      .target_is_multiplex, .sub_working, .sub_burst, .end_intr_pending,
      .all_burst, .chan_operational, .unit_available, .cond_code,
      .release_cpu, .bus_out, .address_out, .select_out, .command_out,
      .operational_in, .status_in, .select_in, .bus_in, .service_out,
      .interrupt_request, .status_accepted_wait, .mem_req, .mem_write,
      .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .prot_key_reg,
      .ccw_addr_reg, .ccw_cmd_reg, .ccw_data_reg, .ccw_valid, .op_started);
   cio_partner u_cio_partner (.clk, .nrst, .mode, .dev_status(ds), .channel_address_word,
      .channel_command_word, .address_out, .select_out, .command_out, .service_out,
      .operational_in, .status_in, .select_in, .bus_in, .mem_req,
      .mem_addr, .mem_ack, .mem_rdata);
   //=====================================================================
   // Access tasks
   task automatic chk(input string nm, input logic [63:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic ins(input logic [3:0] k, input logic [7:0] ua);
      int n;
      @(posedge clk);
      select_channel <= 1'b1;
      {start_io, test_io, halt_io, test_channel} <= k;
      unit_address_bus_out <= ua;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (release_cpu !== 1'b1 && n < 3000);
      if (n >= 3000)
         chk("release", 0, 1);
      cc = cond_code;
      @(posedge clk);
      {select_channel, start_io, test_io, halt_io, test_channel} <= 5'h00;
      @(negedge clk);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (!nrst) begin
         nw <= 0;
         ops <= 0;
         lc <= 8'hff;
      end else begin
         if (mem_req && mem_write && mem_ack) begin
            wd <= mem_wdata;
            nw <= nw + 1;
         end
         if (command_out)
            lc <= bus_out;
         if (op_started)
            ops <= ops + 1;
      end
   end
   // Twenty instructions of a few hundred cycles each at most.
   initial begin
      #(40 * 30000);
      mismatches++;
      results();
   end
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      {select_channel, start_io, test_io, halt_io, test_channel} = 5'h00;
      unit_address_bus_out = 8'h21;
      {sv, mode, ds, channel_address_word, channel_command_word} = '0;
      {mismatches, num_checks} = '0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      foreach (tab[i]) begin
         @(posedge clk);
         sv <= tab[i][12:6];
         ins(tab[i][5:2], 8'h21);
         chk("table code", cc, tab[i][1:0]);
      end
      chk("halt irq", interrupt_request, 1'b1);
      chk("burst halt wait", status_accepted_wait, 1'b1);
      @(posedge clk);
      sv <= 7'h03;
      ins(4'h1, 8'h00);
      chk("tch pending", cc, CC_STORED);
      ins(4'h4, 8'h21);
      chk("tio match store", nw, 1);
      chk("tio irq clear", interrupt_request, 1'b0);
      ins(4'h4, 8'h15);
      chk("tio idle code", cc, CC_AVAIL);
      chk("tio command", lc, CMD_TEST_IO);
      ds <= STAT_BUSY | STAT_MODIFIER;
      ins(4'h4, 8'h15);
      chk("tio status code", cc, CC_STORED);
      chk("tio word", wd, {24'h0, 8'h15, ds, 24'h0});
      ins(4'h2, 8'h15);
      chk("halt avail", cc, CC_STORED);
      chk("halt status", wd[31:16], 16'h0);
      mode <= 2'h1;
      ins(4'h2, 8'h15);
      chk("halt select in", cc, CC_NOTOP);
      {mode, ds} <= {2'h3, STAT_BUSY};
      ins(4'h2, 8'h15);
      chk("halt cu busy", cc, CC_STORED);
      chk("halt cu status", wd[31:16], {STAT_BUSY, 8'h00});
      {mode, ds, channel_address_word, channel_command_word} <= {2'h0, 8'h00, 32'h50000100, 32'h01002000};
      ins(4'h8, 8'h40);
      chk("sio code", cc, CC_AVAIL);
      chk("sio started", ops, 1);
      chk("sio command out", lc, channel_command_word[31:24]);
      chk("sio next ccw", ccw_addr_reg, 24'h000108);
      chk("sio ccw valid", ccw_valid, 1'b1);
      chk("sio key", prot_key_reg, 4'h5);
      chk("sio ccw", {ccw_cmd_reg, ccw_data_reg}, channel_command_word);
      foreach (bad[i]) begin
         {channel_address_word, channel_command_word} <= bad[i];
         ins(4'h8, 8'h40);
         chk("bad code", cc, CC_STORED);
         chk("bad status", wd[23:16], CHST_PROG_CHECK);
         chk("bad no start", ops, 1);
      end
      results();
   end
endmodule
bind cio_handler cio_handler_props u_cio_handler_props (.clk, .nrst,
   .select_channel, .start_io, .halt_io, .test_channel, .sub_working,
   .sub_burst,
   .all_burst, .chan_operational, .interrupt_request, .operational_in,
   .cond_code, .release_cpu, .address_out, .select_out, .mem_req,
   .mem_write, .mem_addr, .op_started, .ccw_cmd_reg);
`default_nettype wire

// ==== tb/cio_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module cio_partner
   import cio_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [1:0] mode,
   input wire logic [7:0] dev_status,
   input wire logic [31:0] channel_address_word,
   input wire logic [31:0] channel_command_word,
   input wire logic address_out,
   input wire logic select_out,
   input wire logic command_out,
   input wire logic service_out,
   output logic operational_in,
   output logic status_in,
   output logic select_in,
   output logic [7:0] bus_in,
   input wire logic mem_req,
   input wire logic [23:0] mem_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [3:0] dly;
   //=====================================================================
   // Control unit and storage
   // Mode 0 answers operational, 1 returns select in, 2 stays silent,
   // 3 gives the short control unit busy answer.
   always_ff @(posedge clk) begin
      if (!nrst || !select_out || operational_in || select_in)
         dly <= 4'h0;
      else
         dly <= dly + 4'h1;
   end
   always_ff @(posedge clk) begin
      if (!nrst || service_out || address_out && !select_out) begin
         operational_in <= 1'b0;
         status_in <= 1'b0;
      end else begin
         operational_in <= operational_in || dly == 4'h3 && mode == 2'h0;
         status_in <= status_in || command_out && operational_in ||
            dly == 4'h3 && mode == 2'h3;
      end
      select_in <= nrst && select_out && (select_in || dly == 4'h3 &&
         mode == 2'h1);
   end
   // Released bus shows the inverse so a stale status cannot pass.
   assign bus_in = status_in ? dev_status : ~dev_status;
   always_ff @(posedge clk) begin
      mem_ack <= nrst && mem_req && !mem_ack;
      if (!nrst)
         mem_rdata <= 32'h5a5aa5a5;
      else if (mem_req && !mem_ack)
         mem_rdata <= mem_addr == ADDR_ADDRESS_WORD ? channel_address_word :
            (mem_addr == channel_address_word[23:0] ? channel_command_word : 32'h00000010);
      else
         mem_rdata <= ~mem_rdata;
   end
endmodule
`default_nettype wire
